// file: testbench/cmr_asserts.sv
`timescale 1ns/1ps
`include "cmr_regs.vh"
module cmr_asserts
(
    // Clock, reset and bus
    input wire mclk,
    input wire reset_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    // Frame output
    input wire tx_valid,
    input wire tx_ready,
    input wire [28:0] tx_id,
    input wire [63:0] tx_data,
    input wire [3:0] tx_len,
    // Health inputs and pack controls
    input wire [7:0] chip_fault_mask,
    input wire [7:0] controller_fault,
    input wire [3:0] chip_count,
    input wire can_term_on,
    input wire [95:0] balance_en,
    input wire hvc_alert
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `CMR_CTRL_ADDR && wb_sel_i[0];
    wire rsp = tx_valid && tx_id[28:16] == 13'h01DF;
    wire hlth = tx_valid && tx_id == `CMR_ID_HEALTH;
    AST_BUS_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one-cycle pulse");
    AST_TERM_ON: assert property (ctl_wr && wb_dat_i[2] && !wb_dat_i[3] |=> ##[0:2] can_term_on)
        else $error("termination not on");
    AST_TERM_OFF: assert property (ctl_wr && wb_dat_i[3] && !wb_dat_i[2] |=> ##[0:2] !can_term_on)
        else $error("termination not off");
    AST_BAL_OFF: assert property (ctl_wr && wb_dat_i[1] && !wb_dat_i[0] |=> ##[0:3] balance_en == 96'h0)
        else $error("balancing not off");
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_id) && $stable(tx_data))
        else $error("frame not held");
    AST_TX_GAP: assert property (tx_valid && tx_ready |=> !tx_valid)
        else $error("valid held after accept");
    AST_TX_ID: assert property (tx_valid |-> hlth || (rsp && tx_id[15:8] >= 8'h09 && tx_id[15:8] <= 8'h0B
        && tx_id[7:6] == 2'h0 && !tx_id[3]))
        else $error("bad frame id");
    AST_HEALTH: assert property (hlth |-> tx_len == 4'h5 && tx_data[15:8] <= 8'h03 && tx_data[23:16] ==
        controller_fault && tx_data[31:24] == chip_fault_mask && tx_data[39:32] == {4'h0, chip_count})
        else $error("health payload wrong");
    AST_RSP_LEN: assert property (rsp |-> tx_len == 4'h8)
        else $error("bad reply length");
    cover property (hlth && tx_ready);
    cover property (rsp && tx_ready && tx_id[15:8] == 8'h0B);
    cover property ($rose(hvc_alert));
endmodule // cmr_asserts
bind cmr_cell_monitor cmr_asserts u_asserts (.*);

// file: testbench/cmr_can_host.sv
`timescale 1ns/1ps
`include "cmr_regs.vh"
module cmr_can_host
(
    // Frames from the monitor
    input wire mclk,
    input wire tx_valid,
    input wire [28:0] tx_id,
    input wire [63:0] tx_data,
    output reg tx_ready = 1'b0,
    // Requests to the monitor
    output reg rx_valid = 1'b0,
    output reg [28:0] rx_id = 29'h0
);
    reg slow = 1'b0;
    reg [28:0] rsp_id [$];
    reg [63:0] rsp_data [$];
    reg [63:0] health_data = 64'h0;
    integer health_cnt = 0;
    always @(posedge mclk)
    begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready && tx_id == `CMR_ID_HEALTH)
        begin
            health_data <= tx_data;
            health_cnt <= health_cnt + 1;
        end
        else if (tx_valid && tx_ready)
        begin
            rsp_id.push_back(tx_id);
            rsp_data.push_back(tx_data);
        end
    end
    task send_req(input [1:0] unit, input [2:0] chip);
    begin
        @(posedge mclk);
        rx_valid <= 1'b1;
        rx_id <= `CMR_ID_REQ | {23'h0, unit, 1'b0, chip};
        @(posedge mclk);
        rx_valid <= 1'b0;
        rx_id <= ~rx_id;
    end
    endtask
endmodule // cmr_can_host

// file: testbench/tb.sv
`timescale 1ns/1ps
`include "cmr_regs.vh"
module tb;
    reg mclk = 1'b0;
    reg reset_n = 1'b0;
    reg wb_cyc_i = 1'b0;
    reg wb_stb_i = 1'b0;
    reg wb_we_i = 1'b0;
    reg [7:0] wb_adr_i = 8'h00;
    reg [3:0] wb_sel_i = 4'h0;
    reg [31:0] wb_dat_i = 32'h0;
    reg meas_valid = 1'b0;
    reg [6:0] meas_cell = 7'h00;
    reg [15:0] meas_mv = 16'h0000;
    reg therm_valid = 1'b0;
    reg therm_open = 1'b0;
    reg therm_short = 1'b0;
    reg [7:0] therm_temp = 8'h00;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, tx_valid, tx_ready, rx_valid, can_term_on, hvc_alert, lvc_alert, overtemp_alert;
    wire [28:0] tx_id, rx_id;
    wire [63:0] tx_data;
    wire [3:0] tx_len;
    wire [95:0] balance_en;
    integer err_total = 0;
    integer num_checks = 0;
    integer i;
    reg [31:0] q;
    always #5 mclk = ~mclk;
    cmr_cell_monitor dut
    (
        .mclk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .meas_valid, .meas_cell, .meas_mv, .therm_idx(6'h00), .therm_valid, .therm_temp, .therm_open,
        .therm_short, .therm_detect(40'h3), .chip_fault_mask(8'hA5), .controller_fault(8'h3C),
        .chip_count(4'h4), .rx_valid, .rx_id, .tx_valid, .tx_ready, .tx_id, .tx_data, .tx_len,
        .can_term_on, .balance_en, .hvc_alert, .lvc_alert, .overtemp_alert
    );
    cmr_can_host host (.mclk, .tx_valid, .tx_id, .tx_data, .tx_ready, .rx_valid, .rx_id);
    task test_done;
    begin
        $display("mismatches %0d of %0d checks", err_total, num_checks);
        if (err_total == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    task chk(input string nm, input [63:0] got, input [63:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
        end
    end
    endtask
    task bail(input integer n, input integer lim);
    begin
        if (n >= lim)
        begin
            chk("timeout", 1, 0);
            test_done;
        end
    end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
        integer n;
    begin
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        n = 0;
        @(posedge mclk);
        while (wb_ack_o !== 1'b1 && n < 20)
        begin
            n = n + 1;
            @(posedge mclk);
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_sel_i <= 4'h0;
        bail(n, 20);
    end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        wb(1'b1, a, d);
    endtask
    task rd(input [7:0] a, input [31:0] m, input [31:0] e, input string nm);
    begin
        wb(1'b0, a, 32'h0);
        chk(nm, q & m, e);
    end
    endtask
    task feed(input [15:0] base, input [15:0] inc);
    begin
        for (i = 0; i < 96; i = i + 1)
        begin
            @(posedge mclk);
            meas_valid <= 1'b1;
            meas_cell <= i[6:0];
            meas_mv <= base + i[15:0] * inc;
        end
        @(posedge mclk);
        meas_valid <= 1'b0;
        repeat (4) @(posedge mclk);
    end
    endtask
    task th(input [7:0] t, input o, input s, input [2:0] cls);
    begin
        @(posedge mclk);
        therm_valid <= 1'b1;
        therm_temp <= t;
        therm_open <= o;
        therm_short <= s;
        @(posedge mclk);
        therm_valid <= 1'b0;
        repeat (4) @(posedge mclk);
        wb(1'b0, `CMR_THT_ADDR, 32'h0);
        chk("therm", {q[12], q[10:8]}, {$signed(t) > 50, cls});
    end
    endtask
    task rcheck(input [7:0] ub);
        integer k, j, n;
        reg [63:0] e;
    begin
        n = 0;
        while (host.rsp_id.size() < 3 && n < 400)
        begin
            n = n + 1;
            @(posedge mclk);
        end
        bail(n, 400);
        for (k = 0; k < 3; k = k + 1)
        begin
            for (j = 0; j < 4; j = j + 1)
                e[16*j +: 16] = 16'h0BD0 + 4 * k + j;
            chk("rsp_id", host.rsp_id.pop_front(), {13'h01DF, 8'h09 + k[7:0], ub});
            chk("rsp_data", host.rsp_data.pop_front(), e);
        end
    end
    endtask
    initial
    begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        chk("term", can_term_on, 0);
        rd(`CMR_STAT_ADDR, 32'h30, 32'h0, "stat");
        rd(`CMR_ID_ADDR, 32'h7, 32'h1, "id");
        for (i = 0; i < 4; i = i + 1)
            rd(`CMR_HVCC_ADDR + 8'h04 * i[7:0], 32'h80000000, 32'h80000000, "na");
        rd(8'hFC, 32'hFFFFFFFF, 32'h0, "unmapped");
        wr(`CMR_PERIOD_ADDR, 32'h32);
        wr(`CMR_CTRL_ADDR, 32'h4);
        chk("term", can_term_on, 1);
        wr(`CMR_CTRL_ADDR, 32'h8);
        chk("term", can_term_on, 0);
        wr(`CMR_CTRL_ADDR, 32'h1);
        rd(`CMR_STAT_ADDR, 32'h10, 32'h10, "bal");
        wr(`CMR_HVC_ADDR, 32'hFA0);
        wr(`CMR_HVCC_ADDR, 32'hF3C);
        rd(`CMR_HVCC_ADDR, 32'h8000FFFF, 32'hF3C, "hvcc");
        feed(16'h1004, 16'h0);
        chk("hvc", hvc_alert, 1);
        feed(16'h0F6E, 16'h0);
        chk("hvc", hvc_alert, 1);
        feed(16'h0F0A, 16'h0);
        chk("hvc", hvc_alert, 0);
        wr(`CMR_HVC_ADDR, 32'h0);
        wr(`CMR_LVC_ADDR, 32'hAF0);
        wr(`CMR_LVCC_ADDR, 32'hBB8);
        feed(16'h0A8C, 16'h0);
        chk("lvc", lvc_alert, 1);
        feed(16'h0B54, 16'h0);
        chk("lvc", lvc_alert, 1);
        feed(16'h0C1C, 16'h0);
        chk("lvc", lvc_alert, 0);
        wr(`CMR_BVMIN_ADDR, 32'hDAC);
        feed(16'h0D48, 16'h0);
        chk("balance", |balance_en, 0);
        wr(`CMR_BVC_ADDR, 32'hE74);
        feed(16'h0ED8, 16'h0);
        chk("balance", &balance_en, 1);
        wr(`CMR_CTRL_ADDR, 32'h2);
        i = host.health_cnt + 2;
        repeat (300) @(posedge mclk);
        chk("health_n", host.health_cnt >= i, 1);
        chk("flags", host.health_data[2], 1);
        chk("health", host.health_data[39:8], 32'h04A53C00);
        wr(`CMR_THEN_ADDR, 32'h110);
        th(8'h3C, 1'b0, 1'b0, 3'h5);
        chk("overtemp", overtemp_alert, 1);
        th(8'hFB, 1'b0, 1'b0, 3'h4);
        th(8'h14, 1'b1, 1'b0, 3'h2);
        th(8'h14, 1'b0, 1'b1, 3'h3);
        host.slow <= 1'b1;
        feed(16'h0BB8, 16'h1);
        host.send_req(2'h0, 3'h2);
        rcheck(8'h02);
        wr(`CMR_ID_ADDR, 32'h2);
        host.send_req(2'h0, 3'h2);
        repeat (100) @(posedge mclk);
        chk("foreign", host.rsp_id.size(), 0);
        host.send_req(2'h1, 3'h2);
        rcheck(8'h12);
        wr(`CMR_CTRL_ADDR, 32'hE0);
        rd(`CMR_CELL_ADDR, 32'hFFFF0000, 32'h0, "stats");
        rd(`CMR_CONF_ADDR, 32'hFF, 32'hFF, "lock");
        rd(`CMR_THEN_ADDR, 32'h3, 32'h3, "th_all");
        wr(`CMR_CTRL_ADDR, 32'h10);
        rd(`CMR_ID_ADDR, 32'h7, 32'h1, "id");
        rd(`CMR_HVCC_ADDR, 32'h80000000, 32'h80000000, "na");
        test_done;
    end
endmodule // tb

// file: verilog/cmr_cell_monitor.v
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "cmr_regs.vh"
module cmr_cell_monitor
(
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Cell and thermistor measurement feed, same clock
    input wire meas_valid,
    input wire [6:0] meas_cell,
    input wire [15:0] meas_mv,
    input wire [5:0] therm_idx,
    input wire therm_valid,
    input wire [7:0] therm_temp,
    input wire therm_open,
    input wire therm_short,
    input wire [39:0] therm_detect,
    input wire [7:0] chip_fault_mask,
    input wire [7:0] controller_fault,
    input wire [3:0] chip_count,
    // CAN receive frame
    input wire rx_valid,
    input wire [28:0] rx_id,
    // CAN transmit frame
    output reg tx_valid,
    input wire tx_ready,
    output reg [28:0] tx_id,
    output reg [63:0] tx_data,
    output reg [3:0] tx_len,
    // Pack controls
    output reg can_term_on,
    output reg [95:0] balance_en,
    output reg hvc_alert,
    output reg lvc_alert,
    output reg overtemp_alert
);
    localparam S_IDLE = 4'b0001;
    localparam S_HLTH = 4'b0010;
    localparam S_RSP = 4'b0100;
    localparam S_WAIT = 4'b1000;

    reg rs1_r, rs_r;
    reg [15:0] hvc_r, lvc_r, hvcc_r, lvcc_r, bvc_r, bvmin_r;
    reg [7:0] thmax_r;
    reg [2:0] unit_id_r;
    reg [39:0] th_en_r;
    reg [47:0] map_r;
    reg [95:0] conf_r, disc_r;
    reg bal_on_r;
    reg [15:0] cell_r [0:95];
    reg [15:0] cmin_r [0:95];
    reg [15:0] cmax_r [0:95];
    reg [95:0] hvc_st_r, lvc_st_r, bvc_st_r;
    reg [7:0] ttemp_r [0:39];
    reg [2:0] tcls_r [0:39];
    reg [39:0] tover_r;
    reg [31:0] period_r, tick_r;
    reg [3:0] st_r;
    reg [1:0] frame_r;
    reg [2:0] req_chip_r;
    reg [1:0] req_unit_r;
    reg req_pend_r, hlth_pend_r;
    reg [6:0] sel_cell_r;
    reg [5:0] sel_th_r;
    reg [7:0] status_flags;
    integer i, j;

    // Zero clear value means the feature is bypassed
    function clr_used;
        input [15:0] v;
        clr_used = (v != 16'h0000);
    endfunction

    function [63:0] cells4;
        input [6:0] base;
        cells4 = {cell_r[base + 7'd3], cell_r[base + 7'd2], cell_r[base + 7'd1], cell_r[base]};
    endfunction

    wire [6:0] mc = meas_cell;
    wire [5:0] ti = therm_idx;
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
    wire [1:0] rx_unit = rx_id[5:4];
    wire req_hit = rx_valid && ((rx_id & `CMR_ID_REQ_MASK) == `CMR_ID_REQ)
        && (rx_unit == unit_id_r[1:0] - 2'd1);

    always @*
    begin
        status_flags = {2'b00, can_term_on, bal_on_r, overtemp_alert, |bvc_st_r, lvc_alert, hvc_alert};
    end

    // Reset release through two flops
    always @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rs1_r <= 1'b0;
            rs_r <= 1'b0;
        end
        else
        begin
            rs1_r <= 1'b1;
            rs_r <= rs1_r;
        end
    end

    // Register file
    always @(posedge mclk or negedge rs_r)
    begin
        if (!rs_r)
        begin
            hvc_r <= `CMR_HVC_RST;
            lvc_r <= `CMR_LVC_RST;
            hvcc_r <= 16'h0000;
            lvcc_r <= 16'h0000;
            bvc_r <= 16'h0000;
            bvmin_r <= 16'h0000;
            thmax_r <= `CMR_THMAX_RST;
            unit_id_r <= `CMR_ID_RST;
            th_en_r <= 40'h0;
            map_r <= 48'h0;
            conf_r <= 96'h0;
            bal_on_r <= 1'b0;
            can_term_on <= 1'b0;
            period_r <= `CMR_PERIOD_RST;
            sel_cell_r <= 7'h00;
            sel_th_r <= 6'h00;
        end
        else if (wb_wr)
        begin
            if (wb_adr_i == `CMR_CTRL_ADDR)
            begin
                if (wb_dat_i[`CMR_CTRL_RST_CFG])
                begin
                    hvc_r <= `CMR_HVC_RST;
                    lvc_r <= `CMR_LVC_RST;
                    hvcc_r <= 16'h0000;
                    lvcc_r <= 16'h0000;
                    bvc_r <= 16'h0000;
                    bvmin_r <= 16'h0000;
                    thmax_r <= `CMR_THMAX_RST;
                    unit_id_r <= `CMR_ID_RST;
                    th_en_r <= 40'h0;
                    map_r <= 48'h0;
                    bal_on_r <= 1'b0;
                    can_term_on <= 1'b0;
                    period_r <= `CMR_PERIOD_RST;
                end
                else
                begin
                    if (wb_dat_i[`CMR_CTRL_BAL_EN])
                        bal_on_r <= 1'b1;
                    else if (wb_dat_i[`CMR_CTRL_BAL_DIS])
                        bal_on_r <= 1'b0;
                    if (wb_dat_i[`CMR_CTRL_TERM_EN])
                        can_term_on <= 1'b1;
                    else if (wb_dat_i[`CMR_CTRL_TERM_DIS])
                        can_term_on <= 1'b0;
                    if (wb_dat_i[`CMR_CTRL_TH_ALL])
                        th_en_r <= th_en_r | therm_detect;
                end
                if (wb_dat_i[`CMR_CTRL_LOCK])
                    conf_r <= disc_r;
            end
            else if (wb_adr_i == `CMR_HVC_ADDR)
                hvc_r <= wb_dat_i[15:0];
            else if (wb_adr_i == `CMR_LVC_ADDR)
                lvc_r <= wb_dat_i[15:0];
            else if (wb_adr_i == `CMR_HVCC_ADDR)
                hvcc_r <= wb_dat_i[15:0];
            else if (wb_adr_i == `CMR_LVCC_ADDR)
                lvcc_r <= wb_dat_i[15:0];
            else if (wb_adr_i == `CMR_BVC_ADDR)
                bvc_r <= wb_dat_i[15:0];
            else if (wb_adr_i == `CMR_BVMIN_ADDR)
                bvmin_r <= wb_dat_i[15:0];
            else if (wb_adr_i == `CMR_THMAX_ADDR)
                thmax_r <= wb_dat_i[7:0];
            else if (wb_adr_i == `CMR_ID_ADDR)
            begin
                if (wb_dat_i[2:0] >= 3'd1 && wb_dat_i[2:0] <= 3'd4)
                    unit_id_r <= wb_dat_i[2:0];
            end
            else if (wb_adr_i == `CMR_THEN_ADDR)
            begin
                // Chip 0..7 and thermistor 1..5; other thermistor codes are dropped
                if (wb_dat_i[6:4] >= 3'd1 && wb_dat_i[6:4] <= 3'd5)
                    th_en_r[wb_dat_i[2:0] * 5 + wb_dat_i[6:4] - 1] <= wb_dat_i[`CMR_THEN_ON];
            end
            else if (wb_adr_i == `CMR_MAP_ADDR)
                map_r[wb_dat_i[10:8] * 6 +: 6] <= {wb_dat_i[6:4], wb_dat_i[2:0]};
            else if (wb_adr_i == `CMR_CELL_ADDR)
                sel_cell_r <= wb_dat_i[6:0];
            else if (wb_adr_i == `CMR_THT_ADDR)
                sel_th_r <= wb_dat_i[5:0];
            else if (wb_adr_i == `CMR_PERIOD_ADDR)
                period_r <= (wb_dat_i == 32'h0) ? 32'h1 : wb_dat_i;
        end
    end

    // Read mux; zero-valued HVCC, LVCC, BVC and BVMIN read with the not-applicable bit 31
    always @(posedge mclk or negedge rs_r)
    begin
        if (!rs_r)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i)
            begin
                if (wb_adr_i == `CMR_HVC_ADDR)
                    wb_dat_o <= {16'h0, hvc_r};
                else if (wb_adr_i == `CMR_LVC_ADDR)
                    wb_dat_o <= {16'h0, lvc_r};
                else if (wb_adr_i == `CMR_HVCC_ADDR)
                    wb_dat_o <= {!clr_used(hvcc_r), 15'h0, hvcc_r};
                else if (wb_adr_i == `CMR_LVCC_ADDR)
                    wb_dat_o <= {!clr_used(lvcc_r), 15'h0, lvcc_r};
                else if (wb_adr_i == `CMR_BVC_ADDR)
                    wb_dat_o <= {!clr_used(bvc_r), 15'h0, bvc_r};
                else if (wb_adr_i == `CMR_BVMIN_ADDR)
                    wb_dat_o <= {!clr_used(bvmin_r), 15'h0, bvmin_r};
                else if (wb_adr_i == `CMR_THMAX_ADDR)
                    wb_dat_o <= {24'h0, thmax_r};
                else if (wb_adr_i == `CMR_ID_ADDR)
                    wb_dat_o <= {29'h0, unit_id_r};
                else if (wb_adr_i == `CMR_THEN_ADDR)
                    wb_dat_o <= th_en_r[31:0];
                else if (wb_adr_i == `CMR_MAP_ADDR)
                    wb_dat_o <= map_r[31:0];
                else if (wb_adr_i == `CMR_CELL_ADDR)
                    wb_dat_o <= {cmax_r[sel_cell_r], cell_r[sel_cell_r]};
                else if (wb_adr_i == `CMR_THT_ADDR)
                    wb_dat_o <= {cmin_r[sel_cell_r], 3'h0, tover_r[sel_th_r], 1'b0, tcls_r[sel_th_r],
                        ttemp_r[sel_th_r]};
                else if (wb_adr_i == `CMR_STAT_ADDR)
                    wb_dat_o <= {24'h0, status_flags};
                else if (wb_adr_i == `CMR_FAULT_ADDR)
                    wb_dat_o <= {12'h0, chip_count, controller_fault, chip_fault_mask};
                else if (wb_adr_i == `CMR_CONF_ADDR)
                    wb_dat_o <= conf_r[31:0];
                else if (wb_adr_i == `CMR_DISC_ADDR)
                    wb_dat_o <= disc_r[31:0];
                else if (wb_adr_i == `CMR_BAL_ADDR)
                    wb_dat_o <= balance_en[31:0];
                else if (wb_adr_i == `CMR_THSTAT_ADDR)
                    wb_dat_o <= {24'h0, tover_r[7:0] & th_en_r[7:0]};
                else if (wb_adr_i == `CMR_PERIOD_ADDR)
                    wb_dat_o <= period_r;
                else
                    wb_dat_o <= 32'h0;
            end
        end
    end

    // Cell supervision; alerts latch and release on their clear level
    always @(posedge mclk or negedge rs_r)
    begin
        if (!rs_r)
        begin
            hvc_st_r <= 96'h0;
            lvc_st_r <= 96'h0;
            bvc_st_r <= 96'h0;
            disc_r <= 96'h0;
            balance_en <= 96'h0;
            for (i = 0; i < 96; i = i + 1)
            begin
                cell_r[i] <= 16'h0000;
                cmin_r[i] <= 16'hFFFF;
                cmax_r[i] <= 16'h0000;
            end
        end
        else
        begin
            if (wb_wr && wb_adr_i == `CMR_CTRL_ADDR && wb_dat_i[`CMR_CTRL_RST_STATS])
            begin
                for (i = 0; i < 96; i = i + 1)
                begin
                    cmin_r[i] <= 16'hFFFF;
                    cmax_r[i] <= 16'h0000;
                end
            end
            else if (meas_valid && mc < 7'd96)
            begin
                if (meas_mv < cmin_r[mc])
                    cmin_r[mc] <= meas_mv;
                if (meas_mv > cmax_r[mc])
                    cmax_r[mc] <= meas_mv;
            end
            if (meas_valid && mc < 7'd96)
            begin
                cell_r[mc] <= meas_mv;
                disc_r[mc] <= (meas_mv != 16'h0000);
                if (hvc_r != 16'h0000 && meas_mv > hvc_r)
                    hvc_st_r[mc] <= 1'b1;
                else if (!clr_used(hvcc_r) || meas_mv < hvcc_r)
                    hvc_st_r[mc] <= 1'b0;
                if (lvc_r != 16'h0000 && meas_mv < lvc_r)
                    lvc_st_r[mc] <= 1'b1;
                else if (!clr_used(lvcc_r) || meas_mv > lvcc_r)
                    lvc_st_r[mc] <= 1'b0;
                bvc_st_r[mc] <= clr_used(bvc_r) && meas_mv > bvc_r;
                balance_en[mc] <= bal_on_r && clr_used(bvmin_r) && meas_mv > bvmin_r;
            end
            if (!bal_on_r)
                balance_en <= 96'h0;
        end
    end

    // Thermistor classification and limit flags
    always @(posedge mclk or negedge rs_r)
    begin
        if (!rs_r)
        begin
            tover_r <= 40'h0;
            for (j = 0; j < 40; j = j + 1)
            begin
                ttemp_r[j] <= 8'h00;
                tcls_r[j] <= `CMR_TH_OFF;
            end
        end
        else if (therm_valid && ti < 6'd40)
        begin
            ttemp_r[ti] <= therm_temp;
            tover_r[ti] <= !therm_open && !therm_short && !therm_temp[7] && therm_temp > thmax_r;
            if (!th_en_r[ti])
                tcls_r[ti] <= therm_open ? `CMR_TH_OFF : `CMR_TH_IDLE;
            else if (therm_open)
                tcls_r[ti] <= `CMR_TH_NC;
            else if (therm_short)
                tcls_r[ti] <= `CMR_TH_SHORT;
            else if (therm_temp[7])
                tcls_r[ti] <= `CMR_TH_NEG;
            else
                tcls_r[ti] <= `CMR_TH_OK;
        end
    end

    // Alert outputs
    always @(posedge mclk or negedge rs_r)
    begin
        if (!rs_r)
        begin
            hvc_alert <= 1'b0;
            lvc_alert <= 1'b0;
            overtemp_alert <= 1'b0;
        end
        else
        begin
            hvc_alert <= |hvc_st_r;
            lvc_alert <= |lvc_st_r;
            overtemp_alert <= |(tover_r & th_en_r);
        end
    end

    // CAN transmit sequencer; health frame takes priority over replies
    always @(posedge mclk or negedge rs_r)
    begin
        if (!rs_r)
        begin
            st_r <= S_IDLE;
            tick_r <= 32'h0;
            hlth_pend_r <= 1'b0;
            req_pend_r <= 1'b0;
            req_chip_r <= 3'h0;
            req_unit_r <= 2'h0;
            frame_r <= 2'h0;
            tx_valid <= 1'b0;
            tx_id <= 29'h0;
            tx_data <= 64'h0;
            tx_len <= 4'h0;
        end
        else
        begin
            // A request while a reply is queued is dropped
            if (req_hit && !req_pend_r)
            begin
                req_pend_r <= 1'b1;
                req_chip_r <= rx_id[2:0];
                req_unit_r <= rx_unit;
            end
            case (st_r)
                S_IDLE:
                begin
                    if (hlth_pend_r)
                    begin
                        tx_id <= `CMR_ID_HEALTH;
                        tx_data <= {24'h0, 4'h0, chip_count, chip_fault_mask, controller_fault,
                            6'h0, unit_id_r[1:0] - 2'd1, status_flags};
                        tx_len <= 4'd5;
                        tx_valid <= 1'b1;
                        hlth_pend_r <= 1'b0;
                        st_r <= S_HLTH;
                    end
                    else if (req_pend_r)
                    begin
                        frame_r <= 2'd0;
                        st_r <= S_RSP;
                    end
                end
                S_RSP:
                begin
                    tx_id <= `CMR_ID_RSP | {13'h0, (frame_r == 2'd0) ? `CMR_TYPE_C1 :
                        (frame_r == 2'd1) ? `CMR_TYPE_C5 : `CMR_TYPE_C9,
                        2'b00, req_unit_r, 1'b0, req_chip_r};
                    tx_data <= cells4({3'h0, req_chip_r} * 7'd12 + {3'h0, frame_r, 2'b00});
                    tx_len <= 4'd8;
                    tx_valid <= 1'b1;
                    st_r <= S_WAIT;
                end
                S_HLTH, S_WAIT:
                begin
                    if (tx_ready)
                    begin
                        tx_valid <= 1'b0;
                        if (st_r == S_WAIT && frame_r != 2'd2)
                        begin
                            frame_r <= frame_r + 2'd1;
                            st_r <= S_RSP;
                        end
                        else
                        begin
                            if (st_r == S_WAIT)
                                req_pend_r <= 1'b0;
                            st_r <= S_IDLE;
                        end
                    end
                end
                default:
                    st_r <= S_IDLE;
            endcase
            // Last, so a new tick beats the clear in S_IDLE
            if (tick_r + 32'h1 >= period_r)
            begin
                tick_r <= 32'h0;
                hlth_pend_r <= 1'b1;
            end
            else
                tick_r <= tick_r + 32'h1;
        end
    end
endmodule // cmr_cell_monitor

// file: verilog/cmr_regs.vh
`ifndef CMR_REGS_VH
`define CMR_REGS_VH
// Register byte addresses
`define CMR_CTRL_ADDR 8'h00
`define CMR_HVC_ADDR 8'h04
`define CMR_LVC_ADDR 8'h08
`define CMR_HVCC_ADDR 8'h0C
`define CMR_LVCC_ADDR 8'h10
`define CMR_BVC_ADDR 8'h14
`define CMR_BVMIN_ADDR 8'h18
`define CMR_THMAX_ADDR 8'h1C
`define CMR_ID_ADDR 8'h20
`define CMR_THEN_ADDR 8'h24
`define CMR_MAP_ADDR 8'h28
`define CMR_CELL_ADDR 8'h2C
`define CMR_THT_ADDR 8'h30
`define CMR_STAT_ADDR 8'h34
`define CMR_FAULT_ADDR 8'h38
`define CMR_CONF_ADDR 8'h3C
`define CMR_DISC_ADDR 8'h40
`define CMR_BAL_ADDR 8'h44
`define CMR_THSTAT_ADDR 8'h48
`define CMR_PERIOD_ADDR 8'h4C
// Control register bits (write one to act)
`define CMR_CTRL_BAL_EN 0
`define CMR_CTRL_BAL_DIS 1
`define CMR_CTRL_TERM_EN 2
`define CMR_CTRL_TERM_DIS 3
`define CMR_CTRL_RST_CFG 4
`define CMR_CTRL_RST_STATS 5
`define CMR_CTRL_LOCK 6
`define CMR_CTRL_TH_ALL 7
// Thermistor enable command fields
`define CMR_THEN_ON 8
// Status register bits
`define CMR_ST_HVC 0
`define CMR_ST_LVC 1
`define CMR_ST_BVC 2
`define CMR_ST_OT 3
`define CMR_ST_BAL 4
`define CMR_ST_TERM 5
// Reset values
`define CMR_HVC_RST 16'h0000
`define CMR_LVC_RST 16'h0000
`define CMR_THMAX_RST 8'h32
`define CMR_ID_RST 3'h1
`define CMR_PERIOD_RST 32'h05F5E100
// CAN identifiers
`define CMR_ID_HEALTH 29'h01DD0001
`define CMR_ID_REQ 29'h01DE0800
`define CMR_ID_REQ_MASK 29'h1FFFFFC8
`define CMR_ID_RSP 29'h01DF0000
`define CMR_UNIT_MASK 29'h00000030
`define CMR_CHIP_MASK 29'h00000007
`define CMR_TYPE_C1 8'h09
`define CMR_TYPE_C5 8'h0A
`define CMR_TYPE_C9 8'h0B
// Thermistor class codes
`define CMR_TH_OFF 3'h0
`define CMR_TH_IDLE 3'h1
`define CMR_TH_NC 3'h2
`define CMR_TH_SHORT 3'h3
`define CMR_TH_NEG 3'h4
`define CMR_TH_OK 3'h5
`endif
